// ### logic/dmb_pkg.sv
package dmb_pkg;
  // ------------------------------------------------------------
  // operating modes and sequencer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_GRAPHICS = 2'h0,
    MODE_CHARACTER = 2'h1,
    MODE_MIXED = 2'h2
  } dmb_mode_e;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_ADDR    = 5'h02,
    ST_HOLD    = 5'h04,
    ST_RDWAIT  = 5'h08,
    ST_WRBACK  = 5'h10
  } dmb_state_e;

  // ------------------------------------------------------------
  // widths and counts
  // ------------------------------------------------------------
  localparam int  ADDR_W         = 18;
  localparam int  BUS_W          = 16;
  localparam int  CHAR_ADDR_W    = 13;
  localparam int  REFRESH_W      = 8;
  localparam int  LINE_W         = 4;
  localparam int  HS_W           = 8;
  localparam int  CLK_PER_WORD   = 2;
  localparam int  DISPLAY_CLKS   = 2;
  localparam int  RMW_CLKS_MIN   = 4;
  localparam int  ZOOM_W         = 4;
  localparam logic [REFRESH_W-1:0] REFRESH_RESET = 8'h00;
  localparam logic [BUS_W-1:0]     BUS_RESET     = 16'h0000;
endpackage

// ### logic/dmb_hsync_gen.sv
`timescale 1ns/1ps
// word-time sync generator: position and width counted in word times
module dmb_hsync_gen
  import dmb_pkg::*;
(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  // programming
  input  wire logic [HS_W-1:0] lineWords,
  input  wire logic [HS_W-1:0] syncStart,
  input  wire logic [HS_W-1:0] syncWidth,
  // status
  output logic                 wordTick,
  output logic                 hsyncOut,
  output logic                 hsyncEnd
);
  typedef struct packed {
    logic            phase;
    logic [HS_W-1:0] word;
    logic            sync;
    logic            tick;
    logic            fin;
  } dmb_hs_s;

  dmb_hs_s hs_q;
  dmb_hs_s hs_d;

  // ------------------------------------------------------------
  // counting, resolution one word time = two clocks
  // ------------------------------------------------------------
  always_comb begin
    hs_d = hs_q;
    hs_d.phase = ~hs_q.phase;
    hs_d.tick = hs_q.phase;
    hs_d.fin = 1'b0;
    if (hs_q.phase) begin
      hs_d.word = (hs_q.word >= lineWords) ? '0 : hs_q.word + 1'b1;
      if (hs_d.word == syncStart) begin
        hs_d.sync = 1'b1;
      end else if (hs_d.word == HS_W'(syncStart + syncWidth)) begin
        hs_d.sync = 1'b0;
        hs_d.fin = hs_q.sync;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_q <= '0;
    end else begin
      hs_q <= hs_d;
    end
  end

  assign wordTick = hs_q.tick;
  assign hsyncOut = hs_q.sync;
  assign hsyncEnd = hs_q.fin;
endmodule

// ### logic/dmb_refresh_ctr.sv
`timescale 1ns/1ps
// eight-bit refresh row counter
module dmb_refresh_ctr
  import dmb_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // control
  input  wire logic                 step,
  // value
  output logic [REFRESH_W-1:0]      refreshAddr
);
  typedef struct packed {
    logic [REFRESH_W-1:0] cnt;
  } dmb_rf_s;

  dmb_rf_s rf_q;
  dmb_rf_s rf_d;

  // natural wrap at 8'hff keeps every row visited
  always_comb begin
    rf_d = rf_q;
    if (step) begin
      rf_d.cnt = rf_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_q.cnt <= REFRESH_RESET;
    end else begin
      rf_q <= rf_d;
    end
  end

  assign refreshAddr = rf_q.cnt;
endmodule

// ### logic/dmb_mem_if.sv
`timescale 1ns/1ps
module dmb_mem_if
  import dmb_pkg::*;
#(
  parameter int ZOOM_MAX = 16
)(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // configuration
  input  wire logic [1:0]            opMode,
  input  wire logic                  refreshEnable,
  input  wire logic                  flybackOnlyModify,
  input  wire logic [ZOOM_W-1:0]     zoomFactor,
  input  wire logic [HS_W-1:0]       lineWords,
  input  wire logic [HS_W-1:0]       syncStart,
  input  wire logic [HS_W-1:0]       syncWidth,
  // raster side
  input  wire logic                  displayActive,
  input  wire logic                  vsyncFlyback,
  input  wire logic [ADDR_W-1:0]     displayAddr,
  input  wire logic [LINE_W-1:0]     lineCount,
  input  wire logic                  cursorOn,
  input  wire logic                  blinkPhase,
  input  wire logic                  nextLineGraphics,
  input  wire logic                  lineClear,
  // drawing command side
  input  wire logic                  modifyReq,
  input  wire logic [ADDR_W-1:0]     modifyAddr,
  input  wire logic [BUS_W-1:0]      modifySetMask,
  input  wire logic [BUS_W-1:0]      modifyClrMask,
  input  wire logic [1:0]            modifyPlane,
  output logic                       modifyDone,
  output logic [BUS_W-1:0]           modifyReadWord,
  // memory pins
  input  wire logic [BUS_W-1:0]      adIn,
  output logic [BUS_W-1:0]           adOut,
  output logic                       adOe,
  output logic                       upper_addr_pin_lo,
  output logic                       upper_addr_pin_hi,
  output logic                       addrLatch,
  output logic                       read_data_strobe_n,
  output logic                       blankOut,
  output logic                       hsyncPin
);
  typedef struct packed {
    dmb_state_e            st;
    logic [5:0]            clk;
    logic [5:0]            len;
    logic                  read_modify_write_cycle;
    logic                  refr;
    logic [BUS_W-1:0]      ad;
    logic                  oe;
    logic                  lo;
    logic                  hi;
    logic                  ale;
    logic                  strb_n;
    logic                  blank;
    logic                  hs;
    logic                  done;
    logic [BUS_W-1:0]      rdWord;
    logic [1:0]            plane;
  } dmb_state_s;

  dmb_state_s s_q;
  dmb_state_s s_d;

  logic                    wordTick;
  logic                    hsyncRaw;
  logic                    hsyncEnd;
  logic                    refreshStep;
  logic [REFRESH_W-1:0]    refreshAddr;
  logic [5:0]              zoomLen;
  logic                    modifyAllowed;
  logic [BUS_W-1:0]        cycAddr;
  logic                    upLo;
  logic                    upHi;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  dmb_hsync_gen u_hsync (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .lineWords (lineWords),
    .syncStart (syncStart),
    .syncWidth (syncWidth),
    .wordTick  (wordTick),
    .hsyncOut  (hsyncRaw),
    .hsyncEnd  (hsyncEnd)
  );

  dmb_refresh_ctr u_refresh (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .step        (refreshStep),
    .refreshAddr (refreshAddr)
  );

  // ------------------------------------------------------------
  // cycle choice and pin values
  // ------------------------------------------------------------
  // zoomed display length: two extra clocks per zoom step
  assign zoomLen = 6'(DISPLAY_CLKS) + 6'({zoomFactor, 1'b0});
  // flyback-only keeps drawing invisible at the cost of draw speed
  assign modifyAllowed = !flybackOnlyModify || !displayActive || vsyncFlyback;

  always_comb begin
    cycAddr = displayAddr[BUS_W-1:0];
    upLo = 1'b0;
    upHi = 1'b0;
    unique case (opMode)
      MODE_CHARACTER: begin
        // top three lines carry the line counter, memory shrinks to 8K words
        cycAddr = {lineCount[2:0], displayAddr[CHAR_ADDR_W-1:0]};
        upHi = cursorOn;
        upLo = lineCount[LINE_W-1];
      end
      MODE_MIXED: begin
        if (hsyncRaw) begin
          upHi = nextLineGraphics;
          upLo = lineClear;
        end else begin
          upHi = cursorOn;
          upLo = blinkPhase;
        end
      end
      default: begin
        upHi = displayAddr[17];
        upLo = displayAddr[16];
      end
    endcase
  end

  // ------------------------------------------------------------
  // memory cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.ale = 1'b1;
    s_d.clk = s_q.clk + 1'b1;
    unique case (s_q.st)
      ST_IDLE: begin
        // align first cycle to word boundary
        if (wordTick) begin
          s_d.st = ST_ADDR;
        end
        s_d.clk = '0;
      end
      ST_ADDR: begin
        // clock one: address out, upper pins may move, latch falls
        s_d.ale = 1'b0;
        s_d.oe = 1'b1;
        s_d.read_modify_write_cycle = 1'b0;
        s_d.refr = 1'b0;
        s_d.clk = 6'h01;
        s_d.st = ST_HOLD;
        s_d.len = 6'(DISPLAY_CLKS);
        if (hsyncRaw && refreshEnable) begin
          s_d.refr = 1'b1;
          s_d.ad = {cycAddr[BUS_W-1:REFRESH_W], refreshAddr};
          s_d.lo = upLo;
          s_d.hi = upHi;
        end else if (modifyReq && modifyAllowed) begin
          s_d.read_modify_write_cycle = 1'b1;
          s_d.ad = (opMode == MODE_CHARACTER)
                   ? {lineCount[2:0], modifyAddr[CHAR_ADDR_W-1:0]}
                   : modifyAddr[BUS_W-1:0];
          s_d.lo = (opMode == MODE_GRAPHICS) ? modifyAddr[16] : upLo;
          s_d.hi = (opMode == MODE_GRAPHICS) ? modifyAddr[17] : upHi;
          s_d.len = (zoomFactor > 4'h1) ? zoomLen : 6'(RMW_CLKS_MIN);
          s_d.plane = modifyPlane;
        end else begin
          s_d.ad = cycAddr;
          s_d.lo = upLo;
          s_d.hi = upHi;
          if (zoomFactor != '0 && displayActive) begin
            s_d.len = zoomLen;
          end
        end
        // only true display cycles reach the screen
        s_d.blank = !(displayActive && !hsyncRaw && !s_d.read_modify_write_cycle && !s_d.refr);
      end
      ST_HOLD: begin
        // bus released after the first clock whatever the cycle
        s_d.oe = 1'b0;
        if (s_q.read_modify_write_cycle) begin
          s_d.strb_n = 1'b0;
          s_d.st = ST_RDWAIT;
        end else if (s_q.clk + 1'b1 >= s_q.len) begin
          s_d.st = ST_ADDR;
        end
      end
      ST_RDWAIT: begin
        // sample at the end of the strobe low period, then write back
        if (s_q.clk + 6'h01 >= s_q.len - 6'h01) begin
          s_d.strb_n = 1'b1;
          s_d.rdWord = adIn;
          s_d.ad = (adIn | modifySetMask) & ~modifyClrMask;
          s_d.oe = 1'b1;
          // write-back clock of the modify (clock three at the minimum length): upper pins may change to upLo/upHi outside graphics mode
          s_d.lo = (opMode == MODE_GRAPHICS) ? s_q.lo : upLo;
          s_d.hi = (opMode == MODE_GRAPHICS) ? s_q.hi : upHi;
          s_d.st = ST_WRBACK;
        end
      end
      ST_WRBACK: begin
        // write pulse and turnaround belong to outside logic
        s_d.oe = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ST_ADDR;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    s_d.hs = hsyncRaw;
  end

  // a refresh cycle steps the row counter once it has issued its address
  assign refreshStep = (s_q.st == ST_ADDR) && s_d.refr;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.ale <= 1'b1;
      s_q.strb_n <= 1'b1;
      s_q.blank <= 1'b1;
      s_q.ad <= BUS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  assign adOut = s_q.ad;
  assign adOe = s_q.oe;
  assign upper_addr_pin_lo = s_q.lo;
  assign upper_addr_pin_hi = s_q.hi;
  assign addrLatch = s_q.ale;
  assign read_data_strobe_n = s_q.strb_n;
  assign blankOut = s_q.blank;
  assign hsyncPin = s_q.hs;
  assign modifyDone = s_q.done;
  assign modifyReadWord = s_q.rdWord;
endmodule

// ### dv/dmb_mem_if_props.sv
`timescale 1ns/1ps
// --------------------------------
// memory pin timing checks
// --------------------------------
module dmb_mem_if_props
  import dmb_pkg::*;
#(parameter int ZOOM_MAX = 16)(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              arst_n,
  // modify side
  input wire logic [ZOOM_W-1:0] zoomFactor,
  input wire logic [BUS_W-1:0]  modifySetMask,
  input wire logic [BUS_W-1:0]  modifyClrMask,
  input wire logic              modifyDone,
  input wire logic [BUS_W-1:0]  modifyReadWord,
  // memory pins
  input wire logic [BUS_W-1:0]  adOut,
  input wire logic              adOe,
  input wire logic              upper_addr_pin_lo,
  input wire logic              upper_addr_pin_hi,
  input wire logic              addrLatch,
  input wire logic              read_data_strobe_n,
  input wire logic              blankOut
);
  logic [7:0] cnt_q;
  logic       seen_q;
  logic       rmw_q;
  // clocks since cycle start; the first start has no length to check
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
      rmw_q <= 1'b0;
    end else if (!addrLatch) begin
      cnt_q <= 8'h01;
      seen_q <= 1'b1;
      rmw_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      rmw_q <= rmw_q | ~read_data_strobe_n;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_busTurn;
    !addrLatch |-> adOe ##1 (!adOe && addrLatch);
  endproperty
  a_busTurn: assert property (p_busTurn) else $error("bus not turned");
  property p_evenLen;
    !addrLatch && seen_q |-> !cnt_q[0];
  endproperty
  a_evenLen: assert property (p_evenLen) else $error("odd cycle length");
  property p_rmwLen;
    !addrLatch && rmw_q && zoomFactor <= 4'h1 |-> cnt_q == 8'h04;
  endproperty
  a_rmwLen: assert property (p_rmwLen) else $error("modify cycle length");
  property p_upperHold;
    $changed({upper_addr_pin_hi, upper_addr_pin_lo}) |-> !addrLatch || cnt_q == 8'h03;
  endproperty
  a_upperHold: assert property (p_upperHold) else $error("upper pins moved");
  property p_strobeStart;
    $fell(read_data_strobe_n) |-> $past(addrLatch) == 1'b0;
  endproperty
  a_strobeStart: assert property (p_strobeStart) else $error("strobe late");
  property p_strobeDone;
    $fell(read_data_strobe_n) |-> ##[2:40] modifyDone;
  endproperty
  a_strobeDone: assert property (p_strobeDone) else $error("strobe w/o modify");
  property p_strobeBlank;
    !read_data_strobe_n |-> blankOut;
  endproperty
  a_strobeBlank: assert property (p_strobeBlank) else $error("modify unblanked");
  property p_writeBack;
    modifyDone |-> $past(adOe) && $past(adOut) ==
      ((modifyReadWord | modifySetMask) & ~modifyClrMask);
  endproperty
  a_writeBack: assert property (p_writeBack) else $error("bad write word");
endmodule
bind dmb_mem_if dmb_mem_if_props #(.ZOOM_MAX(ZOOM_MAX)) u_props (.*);

// ### dv/dmb_mem_model.sv
`timescale 1ns/1ps
// --------------------------------
// display memory and pin latches
// --------------------------------
module dmb_mem_model
  import dmb_pkg::*;
(
  // design pins
  input wire logic              sys_clk,
  input wire logic [BUS_W-1:0]  adOut,
  input wire logic              adOe,
  input wire logic              addrLatch,
  input wire logic              read_data_strobe_n,
  input wire logic              upper_addr_pin_lo,
  input wire logic              upper_addr_pin_hi,
  input wire logic              blankOut,
  input wire logic              hsyncPin,
  output logic [BUS_W-1:0]      adIn,
  // bench view
  input wire logic [BUS_W-1:0]  memWord,
  output logic [ADDR_W-1:0]     rmwAddr,
  output logic [BUS_W-1:0]      wrWord,
  output logic [7:0]            rmwLen,
  output logic [7:0]            rmwCount,
  output logic                  blankDly,
  output logic [1:0]            syncPins
);
  logic [ADDR_W-1:0] lastAddr;
  logic [BUS_W-1:0]  noise;
  logic [7:0]        cnt;
  logic              inRmw;
  initial begin
    noise = 16'h0f0f;
    cnt = 8'h00;
    inRmw = 1'b0;
    rmwCount = 8'h00;
  end
  // a released bus flips every clock so stale data cannot pass
  assign adIn = read_data_strobe_n ? noise : memWord;
  // latch address at start, take the write word while the design drives
  always @(posedge sys_clk) begin
    noise <= ~noise;
    // one video stage: blanking travels with the loaded word
    blankDly <= blankOut;
    // last pin pair seen in sync is what the row flop holds at its trailing edge
    if (hsyncPin) syncPins <= {upper_addr_pin_hi, upper_addr_pin_lo};
    cnt <= cnt + 8'h01;
    if (!addrLatch) begin
      lastAddr <= {upper_addr_pin_hi, upper_addr_pin_lo, adOut};
      cnt <= 8'h01;
      if (inRmw) rmwLen <= cnt;
      inRmw <= 1'b0;
    end else if (adOe) begin
      wrWord <= adOut;
    end
    if (!read_data_strobe_n && !inRmw) begin
      inRmw <= 1'b1;
      rmwAddr <= lastAddr;
      rmwCount <= rmwCount + 8'h01;
    end
  end
endmodule

// ### dv/dmb_mem_if_test.sv
`timescale 1ns/1ps
module dmb_mem_if_test
  import dmb_pkg::*;
;
  logic sys_clk = 1'b0, arst_n = 1'b0, refreshEnable = 1'b0, flybackOnlyModify = 1'b0;
  logic displayActive = 1'b1, vsyncFlyback = 1'b0, cursorOn = 1'b0, blinkPhase = 1'b0;
  logic nextLineGraphics = 1'b0, lineClear = 1'b0, modifyReq = 1'b0;
  logic [1:0] opMode = 2'h0, modifyPlane = 2'h0;
  logic [ZOOM_W-1:0] zoomFactor = 4'h0;
  logic [LINE_W-1:0] lineCount = 4'h0;
  logic [HS_W-1:0] lineWords = 8'h28, syncStart = 8'h10, syncWidth = 8'h06;
  logic [ADDR_W-1:0] displayAddr = 18'h2b00f, modifyAddr = 18'h0, rmwAddr;
  logic [BUS_W-1:0] modifySetMask = 16'h0, modifyClrMask = 16'h0, memWord = 16'h0;
  logic [BUS_W-1:0] adIn, adOut, modifyReadWord, wrWord;
  logic modifyDone, adOe, upper_addr_pin_lo, upper_addr_pin_hi, addrLatch;
  logic read_data_strobe_n, blankOut, hsyncPin;
  logic [7:0] rmwLen, rmwCount;
  logic blankDly;
  logic [1:0] syncPins;
  logic [ADDR_W-1:0] addrs[3] = '{18'h2c3a5, 18'h1ffff, 18'h30000};
  logic [BUS_W-1:0] words[3] = '{16'h5a3c, 16'hffff, 16'h0000};
  int nMismatch = 0, checkCount = 0;
  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;
  dmb_mem_if dut (.*);
  dmb_mem_model u_mem (.*);
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (nMismatch == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // next cycle start inside or outside sync
  task automatic ale(input logic hs);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1;
      if (addrLatch === 1'b0 && hsyncPin === hs) break;
    end
    chk("cycle start", i < 400, 1'b1);
  endtask
  task automatic waitHs();
    int i;
    for (i = 0; i < 400 && hsyncPin !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("hsync seen", hsyncPin, 1'b1);
  endtask
  task automatic rmwGo(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] w);
    @(negedge sys_clk);
    modifyAddr = a;
    modifyPlane = a[1:0];
    memWord = w;
    modifySetMask = 16'h00f0;
    modifyClrMask = 16'h0003;
    modifyReq = 1'b1;
  endtask
  // request held until done, then dropped at the next falling edge
  task automatic rmwEnd(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] w);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1;
      if (modifyDone === 1'b1) break;
    end
    @(negedge sys_clk);
    modifyReq = 1'b0;
    chk("done", i < 400, 1'b1);
    chk("read word", modifyReadWord, w);
    chk("write word", wrWord, (w | 16'h00f0) & ~16'h0003);
    chk("rmw addr", rmwAddr, a);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    int n;
    logic [7:0] r;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) arst_n = 1'b1;
    waitHs();
    for (n = 0; n < 400 && hsyncPin === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("hsync width", n, 32'(2 * syncWidth));
    ale(1'b0);
    ale(1'b0);
    chk("gfx addr", {upper_addr_pin_hi, upper_addr_pin_lo, adOut}, displayAddr);
    // back to back modifies during active display
    for (int k = 0; k < 3; k++) begin
      rmwGo(addrs[k], words[k]);
      rmwEnd(addrs[k], words[k]);
    end
    @(negedge sys_clk) zoomFactor = 4'h2;
    rmwGo(18'h00123, 16'h8001);
    rmwEnd(18'h00123, 16'h8001);
    ale(1'b0);
    #8;
    chk("rmw len", rmwLen, 8'h06);
    // flyback-only modify waits for flyback
    @(negedge sys_clk) zoomFactor = 4'h0;
    flybackOnlyModify = 1'b1;
    n = rmwCount;
    rmwGo(18'h00456, 16'h1234);
    repeat (60) @(posedge sys_clk);
    chk("held rmw", rmwCount, n);
    @(negedge sys_clk) vsyncFlyback = 1'b1;
    rmwEnd(18'h00456, 16'h1234);
    @(negedge sys_clk) vsyncFlyback = 1'b0;
    flybackOnlyModify = 1'b0;
    refreshEnable = 1'b1;
    displayActive = 1'b0;
    ale(1'b1);
    ale(1'b1);
    r = adOut[7:0];
    chk("refresh blank", blankOut, 1'b1);
    ale(1'b1);
    chk("refresh row", adOut[7:0], r + 8'h01);
    @(negedge sys_clk) refreshEnable = 1'b0;
    displayActive = 1'b1;
    opMode = 2'h1;
    displayAddr = 18'h3ffff;
    lineCount = 4'ha;
    cursorOn = 1'b1;
    ale(1'b0);
    ale(1'b0);
    chk("char bus", adOut, 16'h5fff);
    chk("char pins", {upper_addr_pin_hi, upper_addr_pin_lo}, 2'b11);
    chk("char blank", blankOut, 1'b0);
    #8;
    chk("video blank", blankDly, 1'b0);
    @(negedge sys_clk) opMode = 2'h2;
    cursorOn = 1'b0;
    blinkPhase = 1'b1;
    nextLineGraphics = 1'b1;
    for (int h = 0; h < 2; h++) begin
      ale(h[0]);
      ale(h[0]);
      chk("mixed pins", {upper_addr_pin_hi, upper_addr_pin_lo}, h ? 2'b10 : 2'b01);
    end
    for (n = 0; n < 400 && hsyncPin === 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("sync pins", syncPins, 2'b10);
    conclude();
  end
  // watchdog well beyond the expected run
  initial begin
    #300000;
    nMismatch++;
    conclude();
  end
endmodule
